// ==== rtl/tracker_supply_pkg.sv ====
// Package with constants and carrier types for the tracker supply supervisor.
package tracker_supply_pkg;

    // -----------------------------------------------------------------
    // Timing constants and tracker count
    // -----------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int SHUTDOWN_HOLD_MS = 1000;
    localparam int SHUTDOWN_HOLD_CYCLES = (CLK_HZ / 1000) * SHUTDOWN_HOLD_MS;
    localparam int STG_TIME_US = 100;
    localparam int STG_CYCLES = (CLK_HZ / 1_000_000) * STG_TIME_US;
    localparam int NUM_TRACKERS = 2;

    // -----------------------------------------------------------------
    // Main state machine states as seen by this block
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_INIT = 3'h0,
        ST_NORMAL = 3'h1,
        ST_SLEEP = 3'h2,
        ST_WAKE = 3'h3,
        ST_STANDBY = 3'h4,
        ST_SAFE_SHUTDOWN = 3'h5
    } main_state_type;

    // Per-tracker comparator bundle.
    typedef struct packed {
        logic over_voltage;
        logic under_voltage;
    } monitor_type;

    // Per-tracker status flags.
    typedef struct packed {
        logic short_to_ground;
        logic over_voltage;
        logic under_voltage;
    } flags_type;

    localparam flags_type FLAGS_RESET = '0;

endpackage

// ==== rtl/tracker_supply_supervisor.sv ====
// Supervision and enable control for two sensor-supply trackers.
`timescale 1ns/1ps
module tracker_supply_supervisor #(
    parameter int NTRK = tracker_supply_pkg::NUM_TRACKERS,
    parameter int STG_CYCLES = tracker_supply_pkg::STG_CYCLES,
    parameter int HOLD_CYCLES = tracker_supply_pkg::SHUTDOWN_HOLD_CYCLES
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RSTN,
    // Main state machine and software configuration.
    input wire tracker_supply_pkg::main_state_type MAIN_STATE,
    input wire logic [NTRK-1:0] SW_ENABLE,
    // Analog monitor comparators.
    input wire tracker_supply_pkg::monitor_type [NTRK-1:0] MONITOR,
    input wire logic OVERTEMP_WARNING,
    input wire logic OVERTEMP_SHUTDOWN,
    // Software flag clears, one pulse per flag bit.
    input wire tracker_supply_pkg::flags_type [NTRK-1:0] FLAG_CLEAR,
    input wire logic OVERTEMP_WARNING_CLEAR,
    // Regulator enables and reset output.
    output logic [NTRK-1:0] TRACKER_ENABLE,
    output logic RESET_OUTPUT_N,
    output logic SUPPLIES_OFF,
    // Status and interrupt.
    output tracker_supply_pkg::flags_type [NTRK-1:0] TRACKER_FLAGS,
    output logic OVERTEMP_WARNING_FLAGS,
    output logic INTERRUPT
);

    // -----------------------------------------------------------------
    // Elaboration checks
    // -----------------------------------------------------------------
    // Zero counts would leave the timers unable to ever expire.
    if (NTRK < 1 || STG_CYCLES < 1 || HOLD_CYCLES < 1) begin : g_bad_param
        $error("tracker_supply_supervisor: bad parameter");
    end

    localparam int CW = $clog2(HOLD_CYCLES + 1);
    localparam int SW = $clog2(STG_CYCLES + 1);

    logic forced_off;
    logic [CW-1:0] hold_ff;
    logic [NTRK-1:0] latched_off_ff;
    logic [NTRK-1:0] ov_event;
    logic [NTRK-1:0] uv_event;
    logic [NTRK-1:0] stg_event;
    logic warn_d_ff;
    logic warn_event;
    logic [NTRK-1:0] any_event;

    // Standby and safe shutdown override the software enables.
    assign forced_off = (MAIN_STATE == tracker_supply_pkg::ST_STANDBY) ||
        (MAIN_STATE == tracker_supply_pkg::ST_SAFE_SHUTDOWN);

    // -----------------------------------------------------------------
    // Thermal shutdown hold timer
    // -----------------------------------------------------------------
    // Reloads while hot, so the off time counts from the last hot cycle.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            hold_ff <= '0;
        end else if (OVERTEMP_SHUTDOWN) begin
            hold_ff <= CW'(HOLD_CYCLES);
        end else if (hold_ff != '0) begin
            hold_ff <= hold_ff - CW'(1);
        end
    end

    // Warning edge detection for the interrupt pulse.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            warn_d_ff <= 1'b0;
        end else begin
            warn_d_ff <= OVERTEMP_WARNING;
        end
    end
    assign warn_event = OVERTEMP_WARNING && !warn_d_ff;

    // -----------------------------------------------------------------
    // Per-tracker supervision
    // -----------------------------------------------------------------
    for (genvar i = 0; i < NTRK; i++) begin : g_trk
        logic [SW-1:0] uv_cnt_ff;
        logic uv_d_ff;
        logic ov_d_ff;

        // Edges of the comparators give one event per trip.
        always_ff @(posedge CLK) begin
            if (!RSTN) begin
                uv_d_ff <= 1'b0;
                ov_d_ff <= 1'b0;
            end else begin
                uv_d_ff <= MONITOR[i].under_voltage;
                ov_d_ff <= MONITOR[i].over_voltage;
            end
        end
        // Reference off gives a zero output, seen by the same comparator.
        assign uv_event[i] = MONITOR[i].under_voltage && !uv_d_ff &&
            TRACKER_ENABLE[i];
        assign ov_event[i] = MONITOR[i].over_voltage && !ov_d_ff;

        // Under-voltage duration counter; saturates after one report.
        always_ff @(posedge CLK) begin
            if (!RSTN) begin
                uv_cnt_ff <= '0;
            end else if (!MONITOR[i].under_voltage || !TRACKER_ENABLE[i]) begin
                uv_cnt_ff <= '0;
            end else if (uv_cnt_ff != SW'(STG_CYCLES)) begin
                uv_cnt_ff <= uv_cnt_ff + SW'(1);
            end
        end
        assign stg_event[i] = TRACKER_ENABLE[i] && MONITOR[i].under_voltage &&
            (uv_cnt_ff == SW'(STG_CYCLES - 1));

        // A fault latch holds the tracker off until software toggles it or standby or safe shutdown is entered.
        always_ff @(posedge CLK) begin
            if (!RSTN) begin
                latched_off_ff[i] <= 1'b0;
            end else if (ov_event[i] || MONITOR[i].over_voltage ||
                         stg_event[i]) begin
                latched_off_ff[i] <= 1'b1;
            end else if (!SW_ENABLE[i] || forced_off) begin
                latched_off_ff[i] <= 1'b0;
            end
        end

        // Enable output.
        always_ff @(posedge CLK) begin
            if (!RSTN) begin
                TRACKER_ENABLE[i] <= 1'b0;
            end else begin
                TRACKER_ENABLE[i] <= SW_ENABLE[i] && !forced_off &&
                    !OVERTEMP_SHUTDOWN && hold_ff == '0 &&
                    !MONITOR[i].over_voltage && !stg_event[i] &&
                    !latched_off_ff[i];
            end
        end

        // Sticky flags: a set in the same cycle as a clear wins.
        always_ff @(posedge CLK) begin
            if (!RSTN) begin
                TRACKER_FLAGS[i] <= tracker_supply_pkg::FLAGS_RESET;
            end else begin
                TRACKER_FLAGS[i].over_voltage <= ov_event[i] ||
                    (TRACKER_FLAGS[i].over_voltage &&
                     !FLAG_CLEAR[i].over_voltage);
                TRACKER_FLAGS[i].under_voltage <= uv_event[i] ||
                    (TRACKER_FLAGS[i].under_voltage &&
                     !FLAG_CLEAR[i].under_voltage);
                TRACKER_FLAGS[i].short_to_ground <= stg_event[i] ||
                    (TRACKER_FLAGS[i].short_to_ground &&
                     !FLAG_CLEAR[i].short_to_ground);
            end
        end
        assign any_event[i] = ov_event[i] || uv_event[i] || stg_event[i];

        // Assertions for this tracker.
        ov_disables_a: assert property (
            @(posedge CLK) disable iff (!RSTN)
            MONITOR[i].over_voltage |=> !TRACKER_ENABLE[i])
            else $error("tracker on during over voltage");
        ov_flag_a: assert property (
            @(posedge CLK) disable iff (!RSTN)
            ov_event[i] |=> TRACKER_FLAGS[i].over_voltage && INTERRUPT)
            else $error("over voltage not flagged");
        stg_off_a: assert property (
            @(posedge CLK) disable iff (!RSTN)
            stg_event[i] |=> !TRACKER_ENABLE[i] &&
            TRACKER_FLAGS[i].short_to_ground)
            else $error("short to ground not handled");
        uv_flag_a: assert property (
            @(posedge CLK) disable iff (!RSTN)
            uv_event[i] |=> TRACKER_FLAGS[i].under_voltage && INTERRUPT)
            else $error("under voltage not flagged");
        flag_sticky_a: assert property (
            @(posedge CLK) disable iff (!RSTN)
            TRACKER_FLAGS[i].under_voltage && !FLAG_CLEAR[i].under_voltage
            |=> TRACKER_FLAGS[i].under_voltage)
            else $error("flag lost without clear");
        ref_off_a: assert property (
            @(posedge CLK) disable iff (!RSTN)
            TRACKER_ENABLE[i] && $rose(MONITOR[i].under_voltage)
            |=> INTERRUPT)
            else $error("zero output not reported");
        mode_off_a: assert property (
            @(posedge CLK) disable iff (!RSTN)
            forced_off |=> !TRACKER_ENABLE[i])
            else $error("tracker on in standby or safe state");
        follow_sw_a: assert property (
            @(posedge CLK) disable iff (!RSTN)
            !SW_ENABLE[i] |=> !TRACKER_ENABLE[i])
            else $error("tracker on without software enable");
        thermal_a: assert property (
            @(posedge CLK) disable iff (!RSTN)
            OVERTEMP_SHUTDOWN |=> !TRACKER_ENABLE[i] [*8])
            else $error("tracker re-enabled too soon");
        stg_cv: cover property (@(posedge CLK) disable iff (!RSTN)
            stg_event[i]);
        ov_cv: cover property (@(posedge CLK) disable iff (!RSTN)
            ov_event[i]);
    end

    // -----------------------------------------------------------------
    // Warning flag, reset output and interrupt
    // -----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            OVERTEMP_WARNING_FLAGS <= 1'b0;
        end else begin
            OVERTEMP_WARNING_FLAGS <= warn_event || (OVERTEMP_WARNING_FLAGS &&
                !OVERTEMP_WARNING_CLEAR);
        end
    end

    // Reset low and every supply off while in safe shutdown.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            RESET_OUTPUT_N <= 1'b0;
            SUPPLIES_OFF <= 1'b1;
        end else begin
            RESET_OUTPUT_N <=
                MAIN_STATE != tracker_supply_pkg::ST_SAFE_SHUTDOWN;
            SUPPLIES_OFF <=
                MAIN_STATE == tracker_supply_pkg::ST_SAFE_SHUTDOWN;
        end
    end

    // One-cycle interrupt pulse for each cycle with any event, however many events share it.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            INTERRUPT <= 1'b0;
        end else begin
            INTERRUPT <= (|any_event) || warn_event;
        end
    end

    warn_flag_a: assert property (
        @(posedge CLK) disable iff (!RSTN)
        warn_event |=> OVERTEMP_WARNING_FLAGS && INTERRUPT)
        else $error("warning not flagged");
    safe_state_a: assert property (
        @(posedge CLK) disable iff (!RSTN)
        MAIN_STATE == tracker_supply_pkg::ST_SAFE_SHUTDOWN
        |=> !RESET_OUTPUT_N && SUPPLIES_OFF && TRACKER_ENABLE == '0)
        else $error("safe state outputs wrong");
    hold_cnt_a: assert property (
        @(posedge CLK) disable iff (!RSTN)
        hold_ff != '0 |=> TRACKER_ENABLE == '0)
        else $error("tracker on during thermal hold");
    warn_cv: cover property (@(posedge CLK) disable iff (!RSTN) warn_event);
    safe_cv: cover property (@(posedge CLK) disable iff (!RSTN)
        !RESET_OUTPUT_N ##1 RESET_OUTPUT_N);

endmodule

// ==== verification/tracker_analog_model.sv ====
// Behavioural model of the two trackers and their monitor comparators.
`timescale 1ns/1ps
module tracker_analog_model (
    // Regulator enables from the supervisor.
    input wire logic [1:0] enable,
    // Reference and fault conditions set by the bench.
    input wire logic ref_on,
    input wire logic [1:0] short_gnd,
    input wire logic [1:0] short_bat,
    // Comparator outputs.
    output tracker_supply_pkg::monitor_type [1:0] mon
);
    // An enabled tracker with the reference off sits at zero volts.
    // A battery short lifts the output whether the tracker is on or not,
    // so it must not be masked by the enable.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            mon[i].over_voltage = short_bat[i];
            mon[i].under_voltage = enable[i] && !short_bat[i] &&
                (!ref_on || short_gnd[i]);
        end
    end
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the tracker supply supervisor.
`timescale 1ns/1ps
module tb;
    // Short counts keep the run brief.
    localparam int STG = 5;
    localparam int HOLD = 20;
    logic CLK = 1'b0;
    logic RSTN = 1'b0;
    tracker_supply_pkg::main_state_type MAIN_STATE =
        tracker_supply_pkg::ST_NORMAL;
    logic [1:0] SW_ENABLE = 2'h3;
    tracker_supply_pkg::monitor_type [1:0] MONITOR;
    logic OVERTEMP_WARNING = 1'b0;
    logic OVERTEMP_SHUTDOWN = 1'b0;
    logic OVERTEMP_WARNING_CLEAR = 1'b0;
    tracker_supply_pkg::flags_type [1:0] FLAG_CLEAR = '0;
    tracker_supply_pkg::flags_type [1:0] TRACKER_FLAGS;
    logic [1:0] TRACKER_ENABLE;
    logic RESET_OUTPUT_N, SUPPLIES_OFF, OVERTEMP_WARNING_FLAGS, INTERRUPT;
    logic ref_on = 1'b1;
    logic [1:0] short_gnd = 2'h0;
    logic [1:0] short_bat = 2'h0;
    int fail_count = 0;
    int checks_done = 0;
    int irq_count = 0;
    int n0;

    tracker_supply_supervisor #(.NTRK(2), .STG_CYCLES(STG),
        .HOLD_CYCLES(HOLD)) tracker_supply_supervisor_inst (
        .CLK(CLK), .RSTN(RSTN), .MAIN_STATE(MAIN_STATE),
        .SW_ENABLE(SW_ENABLE), .MONITOR(MONITOR),
        .OVERTEMP_WARNING(OVERTEMP_WARNING),
        .OVERTEMP_SHUTDOWN(OVERTEMP_SHUTDOWN), .FLAG_CLEAR(FLAG_CLEAR),
        .OVERTEMP_WARNING_CLEAR(OVERTEMP_WARNING_CLEAR),
        .TRACKER_ENABLE(TRACKER_ENABLE), .RESET_OUTPUT_N(RESET_OUTPUT_N),
        .SUPPLIES_OFF(SUPPLIES_OFF), .TRACKER_FLAGS(TRACKER_FLAGS),
        .OVERTEMP_WARNING_FLAGS(OVERTEMP_WARNING_FLAGS),
        .INTERRUPT(INTERRUPT));
    tracker_analog_model tracker_analog_model_inst (.enable(TRACKER_ENABLE),
        .ref_on(ref_on), .short_gnd(short_gnd), .short_bat(short_bat),
        .mon(MONITOR));

    // --------------------------------------------------------------
    // Clock, interrupt pulse counter and shared tasks
    // --------------------------------------------------------------
    // Interrupts are one-cycle pulses, so they are counted, not polled.
    initial begin
        forever #50 CLK = ~CLK;
    end
    always @(posedge CLK) if (INTERRUPT === 1'b1) irq_count++;
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic do_reset();
        // Mid-run resets start on an edge; the first one is low already.
        if (RSTN) begin
            @(posedge CLK);
        end
        RSTN <= 1'b0;
        tick(9);
        chk("reset enables", 8'h0, TRACKER_ENABLE);
        chk("reset flags", 8'h0, TRACKER_FLAGS);
        @(posedge CLK);
        RSTN <= 1'b1;
        tick(3);
        n0 = irq_count;
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic test_states();
        for (int s = 0; s < 6; s++) begin
            @(posedge CLK);
            MAIN_STATE <= tracker_supply_pkg::main_state_type'(s);
            tick(2);
            chk("enables", (s >= 4) ? 8'h0 : 8'h3, TRACKER_ENABLE);
            chk("reset out", (s == 5) ? 8'h0 : 8'h1, RESET_OUTPUT_N);
            chk("all off", (s == 5) ? 8'h1 : 8'h0, SUPPLIES_OFF);
        end
        @(posedge CLK);
        MAIN_STATE <= tracker_supply_pkg::ST_NORMAL;
        SW_ENABLE <= 2'h1;
        tick(2);
        chk("one enable", 8'h1, TRACKER_ENABLE);
        @(posedge CLK);
        SW_ENABLE <= 2'h3;
        $display("test states done");
    endtask
    task automatic test_over_voltage();
        do_reset();
        @(posedge CLK);
        short_bat <= 2'h1;
        tick(3);
        chk("ov enable", 8'h2, TRACKER_ENABLE);
        chk("ov flag", 8'h1, TRACKER_FLAGS[0].over_voltage);
        chk("ov irq", 8'h1, 8'(irq_count - n0));
        @(posedge CLK);
        short_bat <= 2'h0;
        tick(3);
        chk("ov sticky", 8'h1, TRACKER_FLAGS[0].over_voltage);
        chk("other flags", 8'h0, TRACKER_FLAGS[1]);
        @(posedge CLK);
        FLAG_CLEAR[0].over_voltage <= 1'b1;
        @(posedge CLK);
        FLAG_CLEAR <= '0;
        SW_ENABLE <= 2'h2;
        @(posedge CLK);
        SW_ENABLE <= 2'h3;
        tick(3);
        chk("ov cleared", 8'h0, TRACKER_FLAGS[0].over_voltage);
        chk("re-enabled", 8'h3, TRACKER_ENABLE);
        $display("test over voltage done");
    endtask
    task automatic test_under_voltage();
        do_reset();
        @(posedge CLK);
        short_gnd <= 2'h2;
        repeat (2) @(posedge CLK);
        short_gnd <= 2'h0;
        tick(3);
        chk("uv stays on", 8'h3, TRACKER_ENABLE);
        chk("uv flag", 8'h1, TRACKER_FLAGS[1].under_voltage);
        chk("no sg flag", 8'h0, TRACKER_FLAGS[1].short_to_ground);
        @(posedge CLK);
        short_gnd <= 2'h2;
        tick(STG + 4);
        chk("sg enable", 8'h1, TRACKER_ENABLE);
        chk("sg flag", 8'h1, TRACKER_FLAGS[1].short_to_ground);
        // One short dip and one long one give exactly three pulses.
        chk("uv sg irq", 8'h3, 8'(irq_count - n0));
        @(posedge CLK);
        short_gnd <= 2'h0;
        $display("test under voltage done");
    endtask
    task automatic test_reference_off();
        do_reset();
        @(posedge CLK);
        ref_on <= 1'b0;
        tick(3);
        chk("ref uv", 8'h3, {TRACKER_FLAGS[1].under_voltage,
            TRACKER_FLAGS[0].under_voltage});
        chk("ref irq", 8'h1, 8'(irq_count - n0));
        chk("ref stays on", 8'h3, TRACKER_ENABLE);
        @(posedge CLK);
        ref_on <= 1'b1;
        $display("test reference off done");
    endtask
    task automatic test_temperature();
        int n;
        do_reset();
        @(posedge CLK);
        OVERTEMP_WARNING <= 1'b1;
        @(posedge CLK);
        OVERTEMP_WARNING <= 1'b0;
        tick(3);
        chk("warn flag", 8'h1, OVERTEMP_WARNING_FLAGS);
        chk("warn irq", 8'h1, 8'(irq_count - n0));
        @(posedge CLK);
        OVERTEMP_WARNING_CLEAR <= 1'b1;
        OVERTEMP_SHUTDOWN <= 1'b1;
        @(posedge CLK);
        OVERTEMP_WARNING_CLEAR <= 1'b0;
        tick(3);
        chk("warn clear", 8'h0, OVERTEMP_WARNING_FLAGS);
        chk("hot off", 8'h0, TRACKER_ENABLE);
        @(posedge CLK);
        OVERTEMP_SHUTDOWN <= 1'b0;
        // Bounded wait for the trackers to return after the hold.
        n = 0;
        while (TRACKER_ENABLE !== 2'h3) begin
            tick(1);
            n++;
            if (n > 100) begin
                chk("hold wait bound", 8'h0, 8'h1);
                break;
            end
        end
        chk("hold length", 8'h1, 8'(n >= HOLD));
        $display("test temperature done");
    endtask

    initial begin
        do_reset();
        test_states();
        test_over_voltage();
        test_under_voltage();
        test_reference_off();
        test_temperature();
        wrap_up();
    end
endmodule
